// File: wake_event_status_logic_tb_top.sv
`timescale 1ns/1ps
module wake_event_status_logic_tb_top;
  import wes_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en, rd_en, wake_n, master, pend;
  logic [7:0] addr, wdata, rdata, src_a, src_b, src_c, en_a, en_b, en_c;
  logic [7:0] exp_a, exp_b, exp_c, m, v;
  logic [15:0] wake_count;
  int err_count = 0;
  int num_checks = 0;
  int exp_wk = 0;

  always #2 core_clk = ~core_clk;

  wes_wake_status u_wes_wake_status (
    .core_clk(core_clk), .rst(rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .ring_indicate_two_wake(src_a[1]), .ring_indicate_one_wake(src_a[2]),
    .keyboard_wake(src_a[3]), .mouse_wake(src_a[4]), .specific_key_wake(src_a[5]),
    .fan_speed_one_wake(src_a[6]), .fan_speed_two_wake(src_a[7]),
    .general_io_pin_10(src_b[0]), .general_io_pin_11(src_b[1]),
    .general_io_pin_12(src_b[2]), .general_io_pin_13(src_b[3]),
    .general_io_pin_14(src_b[4]), .general_io_pin_15(src_b[5]),
    .general_io_pin_16(src_b[6]), .general_io_pin_17(src_b[7]),
    .general_io_pin_20(src_c[0]), .general_io_pin_21(src_c[1]),
    .general_io_pin_22(src_c[2]), .grouped_device_irq_status(src_c[3]),
    .general_io_pin_24(src_c[4]), .general_io_pin_25(src_c[5]),
    .general_io_pin_26(src_c[6]), .general_io_pin_27(src_c[7]),
    .source_enable_a(en_a), .source_enable_b(en_b), .source_enable_c(en_c),
    .wake_request_out_n(wake_n)
  );

  wes_host_pm u_wes_host_pm (
    .core_clk(core_clk), .rst(rst), .wake_request_out_n(wake_n), .wake_count(wake_count)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge core_clk);
    wr_en = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge core_clk);
    rd_en = 1'b0;
    check(rdata, exp, $sformatf("read of offset %h", a));
  endtask : rd_chk

  // one-cycle wake events, folded into the expected flags
  task automatic pulse(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(negedge core_clk);
    src_a = a;
    src_b = b;
    src_c = c;
    @(negedge core_clk);
    src_a = 8'h00;
    src_b = 8'h00;
    src_c = 8'h00;
    exp_a = exp_a | (a & WES_MASK_A);
    exp_b = exp_b | b;
    exp_c = exp_c | c;
    repeat (3) @(negedge core_clk);
  endtask : pulse

  function automatic logic pend_f();
    return |((exp_a & en_a) | (exp_b & en_b) | (exp_c & en_c));
  endfunction : pend_f

  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    err_count++;
    print_verdict();
  end

  initial begin
    {wr_en, rd_en, addr, wdata, src_a, src_b, src_c, en_a, en_b, en_c} = '0;
    {exp_a, exp_b, exp_c, master, pend} = '0;
    void'($urandom(69));
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'(i), 8'h00);
    end
    // reserved places ignore writes
    wr(WES_OFF_SPARE_A, 8'hff);
    rd_chk(WES_OFF_SPARE_A, 8'h00);
    wr(WES_OFF_SPARE_B, 8'hff);
    rd_chk(WES_OFF_SPARE_B, 8'h00);
    wr(WES_OFF_SUMMARY, 8'hff);
    rd_chk(WES_OFF_SUMMARY, 8'h00);
    wr(WES_OFF_MASTER, 8'hff);
    rd_chk(WES_OFF_MASTER, 8'h01);
    wr(WES_OFF_MASTER, 8'h00);
    // every source bit alone, all enables off
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 8; b++) begin
        v = 8'h01 << b;
        pulse(r == 0 ? v : 8'h00, r == 1 ? v : 8'h00, r == 2 ? v : 8'h00);
        m = (r == 0) ? (v & WES_MASK_A) : v;
        rd_chk(WES_OFF_FLAGS_A + 8'(r), m);
        rd_chk(WES_OFF_SUMMARY, 8'h00);
        wr(WES_OFF_FLAGS_A + 8'(r), ~v);
        rd_chk(WES_OFF_FLAGS_A + 8'(r), m);
        wr(WES_OFF_FLAGS_A + 8'(r), v);
        rd_chk(WES_OFF_FLAGS_A + 8'(r), 8'h00);
        {exp_a, exp_b, exp_c} = '0;
      end
    end
    // event and clear in one cycle: the event wins
    @(negedge core_clk);
    src_b = 8'h01;
    wr_en = 1'b1;
    addr = WES_OFF_FLAGS_B;
    wdata = 8'h01;
    @(negedge core_clk);
    src_b = 8'h00;
    wr_en = 1'b0;
    rd_chk(WES_OFF_FLAGS_B, 8'h01);
    wr(WES_OFF_FLAGS_B, 8'h01);
    rd_chk(WES_OFF_FLAGS_B, 8'h00);
    // random sources, enables and master enable
    for (int i = 0; i < 40; i++) begin
      @(negedge core_clk);
      en_a = 8'($urandom);
      en_b = 8'($urandom);
      en_c = 8'($urandom);
      v = 8'($urandom);
      master = v[0];
      wr(WES_OFF_MASTER, v);
      rd_chk(WES_OFF_MASTER, {7'h00, master});
      pulse(8'($urandom & $urandom), 8'($urandom & $urandom), 8'($urandom & $urandom));
      pend = pend_f();
      if (pend && master) begin
        exp_wk++;
      end
      rd_chk(WES_OFF_FLAGS_A, exp_a);
      rd_chk(WES_OFF_FLAGS_B, exp_b);
      rd_chk(WES_OFF_FLAGS_C, exp_c);
      rd_chk(WES_OFF_SUMMARY, {7'h00, pend});
      check({7'h00, wake_n}, {7'h00, !(pend && master)}, "wake line");
      m = 8'($urandom);
      wr(WES_OFF_FLAGS_A, m);
      exp_a = exp_a & ~m;
      rd_chk(WES_OFF_FLAGS_A, exp_a);
      wr(WES_OFF_FLAGS_A, 8'hff);
      wr(WES_OFF_FLAGS_B, 8'hff);
      wr(WES_OFF_FLAGS_C, 8'hff);
      {exp_a, exp_b, exp_c} = '0;
      wr(WES_OFF_SUMMARY, 8'hfe);
      rd_chk(WES_OFF_SUMMARY, {7'h00, pend});
      check({7'h00, wake_n}, {7'h00, !(pend && master)}, "wake line held");
      wr(WES_OFF_SUMMARY, 8'h01);
      rd_chk(WES_OFF_SUMMARY, 8'h00);
      check({7'h00, wake_n}, 8'h01, "wake line released");
    end
    // standby reset in mid-run with state set
    wr(WES_OFF_MASTER, 8'h01);
    en_a = 8'hff;
    pulse(8'hff, 8'hff, 8'hff);
    check({7'h00, wake_n}, 8'h00, "wake line asserted");
    check(wake_count[7:0], 8'(exp_wk + 1), "host saw wake");
    @(negedge core_clk);
    rst = 1'b1;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    check({7'h00, wake_n}, 8'h01, "wake line after reset");
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'(i), 8'h00);
    end
    print_verdict();
  end
endmodule : wake_event_status_logic_tb_top

// File: wes_flag_bank.sv
`timescale 1ns/1ps
module wes_flag_bank #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] MASK = '1
) (
  // clock and standby reset
  input wire logic core_clk,
  input wire logic rst,
  // events and software clear
  input wire logic [WIDTH-1:0] event_in,
  input wire logic [WIDTH-1:0] clear_in,
  // sticky flags
  output logic [WIDTH-1:0] flags
);
  import wes_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } wes_bank_state_t;

  wes_bank_state_t state_reg;
  wes_bank_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // set wins over a same-cycle clear
    state_next.flags = ((state_reg.flags & ~clear_in) | event_in) & MASK;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flags = state_reg.flags;

  AST_FLAG_STICKS: assert property (@(posedge core_clk) disable iff (rst)
    (|(event_in & MASK)) |=> ((flags & $past(event_in) & MASK) == ($past(event_in) & MASK))
  ) else $error("event did not set its flag");

  AST_FLAG_W1C: assert property (@(posedge core_clk) disable iff (rst)
    (|(clear_in & ~event_in)) |=> ((flags & $past(clear_in) & ~$past(event_in)) == '0)
  ) else $error("write of one did not clear flag");

  AST_FLAG_HOLDS: assert property (@(posedge core_clk) disable iff (rst)
    (clear_in == '0) |=> ((flags & $past(flags)) == $past(flags))
  ) else $error("flag dropped without a clear");
endmodule : wes_flag_bank

// File: wes_host_pm.sv
`timescale 1ns/1ps
module wes_host_pm (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // wake line from the device
  input wire logic wake_request_out_n,
  // wake requests seen by the chipset
  output logic [15:0] wake_count
);
  logic line_prev_reg;
  // counts falling edges of the active-low wake line
  always_ff @(posedge core_clk) begin
    if (rst) begin
      line_prev_reg <= 1'b1;
      wake_count <= 16'h0000;
    end else begin
      line_prev_reg <= wake_request_out_n;
      if (line_prev_reg && !wake_request_out_n) begin
        wake_count <= wake_count + 16'h0001;
      end
    end
  end
endmodule : wes_host_pm

// File: wes_pkg.sv
package wes_pkg;
  localparam int WES_DATA_W = 8;
  localparam int WES_ADDR_W = 8;

  // register offsets within the runtime block
  localparam logic [7:0] WES_OFF_SUMMARY = 8'h00;
  localparam logic [7:0] WES_OFF_SPARE_A = 8'h01;
  localparam logic [7:0] WES_OFF_MASTER = 8'h02;
  localparam logic [7:0] WES_OFF_SPARE_B = 8'h03;
  localparam logic [7:0] WES_OFF_FLAGS_A = 8'h04;
  localparam logic [7:0] WES_OFF_FLAGS_B = 8'h05;
  localparam logic [7:0] WES_OFF_FLAGS_C = 8'h06;

  // field positions
  localparam int WES_PENDING_BIT = 0;
  localparam int WES_ENABLE_BIT = 0;
  localparam int WES_A_RING_TWO_BIT = 1;
  localparam int WES_A_RING_ONE_BIT = 2;
  localparam int WES_A_KEYBOARD_BIT = 3;
  localparam int WES_A_MOUSE_BIT = 4;
  localparam int WES_A_SPEC_KEY_BIT = 5;
  localparam int WES_A_FAN_ONE_BIT = 6;
  localparam int WES_A_FAN_TWO_BIT = 7;
  localparam int WES_C_DEV_IRQ_BIT = 3;

  // implemented bits of each source flag register
  localparam logic [7:0] WES_MASK_A = 8'hfe;
  localparam logic [7:0] WES_MASK_B = 8'hff;
  localparam logic [7:0] WES_MASK_C = 8'hff;

  // standby reset values
  localparam logic [7:0] WES_RST_SUMMARY = 8'h00;
  localparam logic [7:0] WES_RST_MASTER = 8'h00;
  localparam logic [7:0] WES_RST_FLAGS = 8'h00;
  localparam logic [7:0] WES_READ_ZERO = 8'h00;
endpackage : wes_pkg

// File: wes_wake_drive.sv
`timescale 1ns/1ps
module wes_wake_drive (
  // clock and standby reset
  input wire logic core_clk,
  input wire logic rst,
  // enabled source hit, software clear, master enable
  input wire logic source_hit,
  input wire logic pending_clear,
  input wire logic master_enable,
  // pending flag and active-low wake line
  output logic pending,
  output logic wake_request_out_n
);
  import wes_pkg::*;

  typedef struct packed {
    logic pending;
    logic wake_n;
  } wes_drive_state_t;

  wes_drive_state_t state_reg;
  wes_drive_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // pending follows what the line would do, whatever the master enable
    state_next.pending = source_hit | (state_reg.pending & ~pending_clear);
    state_next.wake_n = ~(state_reg.pending & master_enable);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg.pending <= 1'b0;
      state_reg.wake_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pending = state_reg.pending;
  assign wake_request_out_n = state_reg.wake_n;

  AST_DRIVE_ON: assert property (@(posedge core_clk) disable iff (rst)
    (pending && master_enable) |=> !wake_request_out_n
  ) else $error("wake line not driven while pending and enabled");

  AST_DRIVE_OFF: assert property (@(posedge core_clk) disable iff (rst)
    !master_enable |=> wake_request_out_n
  ) else $error("wake line driven with master enable off");

  AST_CLEAR_RELEASES: assert property (@(posedge core_clk) disable iff (rst)
    (pending_clear && !source_hit) ##1 !source_hit |=> wake_request_out_n
  ) else $error("wake line still driven after clear");
endmodule : wes_wake_drive

// File: wes_wake_status.sv
`timescale 1ns/1ps
// Overview of operation
// - pending flag sets whenever the wake line would be driven, master enable ignored.
// - writing one to pending clears it and releases the wake line, unless an enabled, flagged source still hits in that cycle.
// - writing zero to pending changes nothing.
// - master enable bit 0 at offset 02; zero (default) keeps the line idle.
// - master enable and pending survive main, soft and bus resets.
// - standby reset clears summary, master enable and three flag registers.
// - offsets 01 and 03 read as zero.
// - source flags record events regardless of source or master enables.
// - an event sets its source flag; it stays until software clears it.
// - source flags are write-one-to-clear and survive main, soft and bus resets.
// - offset 04: ring two, ring one, keyboard, mouse, key, fan one, fan two.
// - offset 05 bits 0-7 hold general pins 10-17.
// - offset 06: pins 20-22, grouped device irq at bit 3, pins 24-27.
// - a source drives the line only if enabled, flagged and master enabled.
module wes_wake_status (
  // clock and standby power-on reset
  input wire logic core_clk,
  input wire logic rst,
  // runtime register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [wes_pkg::WES_ADDR_W-1:0] reg_addr,
  input wire logic [wes_pkg::WES_DATA_W-1:0] reg_wdata,
  output logic [wes_pkg::WES_DATA_W-1:0] reg_rdata,
  // wake sources for flag register a
  input wire logic ring_indicate_two_wake,
  input wire logic ring_indicate_one_wake,
  input wire logic keyboard_wake,
  input wire logic mouse_wake,
  input wire logic specific_key_wake,
  input wire logic fan_speed_one_wake,
  input wire logic fan_speed_two_wake,
  // wake sources for flag register b
  input wire logic general_io_pin_10,
  input wire logic general_io_pin_11,
  input wire logic general_io_pin_12,
  input wire logic general_io_pin_13,
  input wire logic general_io_pin_14,
  input wire logic general_io_pin_15,
  input wire logic general_io_pin_16,
  input wire logic general_io_pin_17,
  // wake sources for flag register c
  input wire logic general_io_pin_20,
  input wire logic general_io_pin_21,
  input wire logic general_io_pin_22,
  input wire logic grouped_device_irq_status,
  input wire logic general_io_pin_24,
  input wire logic general_io_pin_25,
  input wire logic general_io_pin_26,
  input wire logic general_io_pin_27,
  // per-source enables, one bit per flag bit
  input wire logic [wes_pkg::WES_DATA_W-1:0] source_enable_a,
  input wire logic [wes_pkg::WES_DATA_W-1:0] source_enable_b,
  input wire logic [wes_pkg::WES_DATA_W-1:0] source_enable_c,
  // wake line to the chipset, active low
  output logic wake_request_out_n
);
  import wes_pkg::*;

  typedef struct packed {
    logic master_enable;
    logic [WES_DATA_W-1:0] rdata;
  } wes_top_state_t;

  wes_top_state_t state_reg;
  wes_top_state_t state_next;

  logic [WES_DATA_W-1:0] event_a;
  logic [WES_DATA_W-1:0] event_b;
  logic [WES_DATA_W-1:0] event_c;
  logic [WES_DATA_W-1:0] clear_a;
  logic [WES_DATA_W-1:0] clear_b;
  logic [WES_DATA_W-1:0] clear_c;
  logic [WES_DATA_W-1:0] flags_a;
  logic [WES_DATA_W-1:0] flags_b;
  logic [WES_DATA_W-1:0] flags_c;
  logic source_hit;
  logic pending_clear;
  logic pending;
  logic wake_n;

  function automatic logic wes_hit(
    input logic [WES_DATA_W-1:0] flags,
    input logic [WES_DATA_W-1:0] enables
  );
    wes_hit = |(flags & enables);
  endfunction : wes_hit

  function automatic logic wes_wr_at(
    input logic wr_en,
    input logic [WES_ADDR_W-1:0] addr,
    input logic [WES_ADDR_W-1:0] offset
  );
    wes_wr_at = wr_en && (addr == offset);
  endfunction : wes_wr_at

  // source bit layout
  always_comb begin
    event_a = '0;
    event_a[WES_A_RING_TWO_BIT] = ring_indicate_two_wake;
    event_a[WES_A_RING_ONE_BIT] = ring_indicate_one_wake;
    event_a[WES_A_KEYBOARD_BIT] = keyboard_wake;
    event_a[WES_A_MOUSE_BIT] = mouse_wake;
    event_a[WES_A_SPEC_KEY_BIT] = specific_key_wake;
    event_a[WES_A_FAN_ONE_BIT] = fan_speed_one_wake;
    event_a[WES_A_FAN_TWO_BIT] = fan_speed_two_wake;
  end

  assign event_b = {general_io_pin_17, general_io_pin_16, general_io_pin_15,
                    general_io_pin_14, general_io_pin_13, general_io_pin_12,
                    general_io_pin_11, general_io_pin_10};
  assign event_c = {general_io_pin_27, general_io_pin_26, general_io_pin_25,
                    general_io_pin_24, grouped_device_irq_status,
                    general_io_pin_22, general_io_pin_21, general_io_pin_20};

  // write-one-to-clear strobes
  assign clear_a = wes_wr_at(reg_wr_en, reg_addr, WES_OFF_FLAGS_A) ? reg_wdata : '0;
  assign clear_b = wes_wr_at(reg_wr_en, reg_addr, WES_OFF_FLAGS_B) ? reg_wdata : '0;
  assign clear_c = wes_wr_at(reg_wr_en, reg_addr, WES_OFF_FLAGS_C) ? reg_wdata : '0;
  assign pending_clear = wes_wr_at(reg_wr_en, reg_addr, WES_OFF_SUMMARY)
                         && reg_wdata[WES_PENDING_BIT];

  // any enabled, flagged source would drive the line
  assign source_hit = wes_hit(flags_a, source_enable_a)
                      || wes_hit(flags_b, source_enable_b)
                      || wes_hit(flags_c, source_enable_c);

  wes_flag_bank #(
    .WIDTH(WES_DATA_W),
    .MASK(WES_MASK_A)
  ) u_flags_a (
    .core_clk(core_clk),
    .rst(rst),
    .event_in(event_a),
    .clear_in(clear_a),
    .flags(flags_a)
  );

  wes_flag_bank #(
    .WIDTH(WES_DATA_W),
    .MASK(WES_MASK_B)
  ) u_flags_b (
    .core_clk(core_clk),
    .rst(rst),
    .event_in(event_b),
    .clear_in(clear_b),
    .flags(flags_b)
  );

  wes_flag_bank #(
    .WIDTH(WES_DATA_W),
    .MASK(WES_MASK_C)
  ) u_flags_c (
    .core_clk(core_clk),
    .rst(rst),
    .event_in(event_c),
    .clear_in(clear_c),
    .flags(flags_c)
  );

  wes_wake_drive u_drive (
    .core_clk(core_clk),
    .rst(rst),
    .source_hit(source_hit),
    .pending_clear(pending_clear),
    .master_enable(state_reg.master_enable),
    .pending(pending),
    .wake_request_out_n(wake_n)
  );

  assign wake_request_out_n = wake_n;

  always_comb begin
    state_next = state_reg;
    if (wes_wr_at(reg_wr_en, reg_addr, WES_OFF_MASTER)) begin
      // only bit 0 is stored; reserved bits dropped
      state_next.master_enable = reg_wdata[WES_ENABLE_BIT];
    end
    if (reg_rd_en) begin
      state_next.rdata = WES_READ_ZERO;
      if (reg_addr == WES_OFF_SUMMARY) begin
        state_next.rdata[WES_PENDING_BIT] = pending;
      end else if (reg_addr == WES_OFF_MASTER) begin
        state_next.rdata[WES_ENABLE_BIT] = state_reg.master_enable;
      end else if (reg_addr == WES_OFF_FLAGS_A) begin
        state_next.rdata = flags_a;
      end else if (reg_addr == WES_OFF_FLAGS_B) begin
        state_next.rdata = flags_b;
      end else if (reg_addr == WES_OFF_FLAGS_C) begin
        state_next.rdata = flags_c;
      end else begin
        state_next.rdata = WES_READ_ZERO;
      end
    end
  end

  // only the standby reset reaches this state; other resets are not wired in
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg.master_enable <= WES_RST_MASTER[WES_ENABLE_BIT];
      state_reg.rdata <= WES_READ_ZERO;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;

  AST_PENDING_SETS: assert property (@(posedge core_clk) disable iff (rst)
    source_hit |=> pending
  ) else $error("pending not set by an enabled flagged source");

  AST_PENDING_CLEARS: assert property (@(posedge core_clk) disable iff (rst)
    (pending_clear && !source_hit) |=> !pending
  ) else $error("pending not cleared by write of one");

  AST_ZERO_WRITE_KEEPS: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr_en && reg_addr == WES_OFF_SUMMARY && !reg_wdata[WES_PENDING_BIT] && pending)
    |=> pending
  ) else $error("write of zero changed pending");

  AST_MASTER_WRITE: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr_en && reg_addr == WES_OFF_MASTER)
    |=> (state_reg.master_enable == $past(reg_wdata[WES_ENABLE_BIT]))
  ) else $error("master enable not written");

  AST_MASTER_LINE_IDLE: assert property (@(posedge core_clk) disable iff (rst)
    (!state_reg.master_enable)[*2] |-> wake_request_out_n
  ) else $error("wake line driven while master enable off");

  AST_SPARE_READ_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd_en && (reg_addr == WES_OFF_SPARE_A || reg_addr == WES_OFF_SPARE_B))
    |=> (reg_rdata == WES_READ_ZERO)
  ) else $error("spare offset read nonzero");

  AST_RESERVED_READ_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd_en && (reg_addr == WES_OFF_SUMMARY || reg_addr == WES_OFF_MASTER))
    |=> (reg_rdata[WES_DATA_W-1:1] == '0)
  ) else $error("reserved bits read nonzero");

  AST_DISABLED_SOURCE_FLAGS: assert property (@(posedge core_clk) disable iff (rst)
    (general_io_pin_10 && source_enable_b[0] == 1'b0) |=> flags_b[0]
  ) else $error("disabled source did not record its event");

  AST_STANDBY_RESET: assert property (@(posedge core_clk)
    rst |=> (flags_a == WES_RST_FLAGS && flags_b == WES_RST_FLAGS
             && flags_c == WES_RST_FLAGS && !pending && !state_reg.master_enable)
  ) else $error("standby reset left state nonzero");

  AST_READ_FLAGS_A: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd_en && reg_addr == WES_OFF_FLAGS_A)
    |=> (reg_rdata == $past(flags_a))
  ) else $error("read of flag register a wrong");

  AST_READ_FLAGS_B: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd_en && reg_addr == WES_OFF_FLAGS_B)
    |=> (reg_rdata == $past(flags_b))
  ) else $error("read of flag register b wrong");

  AST_READ_FLAGS_C: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd_en && reg_addr == WES_OFF_FLAGS_C)
    |=> (reg_rdata == $past(flags_c))
  ) else $error("read of flag register c wrong");

  AST_READ_PENDING: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd_en && reg_addr == WES_OFF_SUMMARY)
    |=> (reg_rdata[WES_PENDING_BIT] == $past(pending))
  ) else $error("read of pending flag wrong");

  AST_READ_MASTER: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd_en && reg_addr == WES_OFF_MASTER)
    |=> (reg_rdata[WES_ENABLE_BIT] == $past(state_reg.master_enable))
  ) else $error("read of master enable wrong");

  AST_FLAG_A_SPARE_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    1'b1
    |-> ((flags_a & ~WES_MASK_A) == WES_READ_ZERO)
  ) else $error("reserved bit of flag register a set");

  AST_PENDING_HOLDS: assert property (@(posedge core_clk) disable iff (rst)
    (pending && !pending_clear)
    |=> pending
  ) else $error("pending dropped without a clear");

  AST_PENDING_NEEDS_HIT: assert property (@(posedge core_clk) disable iff (rst)
    (!pending && !source_hit)
    |=> !pending
  ) else $error("pending set without an enabled flagged source");

  AST_LINE_NEEDS_PENDING: assert property (@(posedge core_clk) disable iff (rst)
    !pending
    |=> wake_request_out_n
  ) else $error("wake line driven without pending");

  AST_MASTER_HOLDS: assert property (@(posedge core_clk) disable iff (rst)
    !(reg_wr_en && reg_addr == WES_OFF_MASTER)
    |=> $stable(state_reg.master_enable)
  ) else $error("master enable changed without a write");
endmodule : wes_wake_status
